/* logic/ifi_core.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - opcode 001010 increments operand by one
// - plain increment sets C DC N OV Z
// - opcode 001111 increments, flags stay unchanged
// - destination bit 0 accumulator, 1 memory
// - bank bit picks fast bank or banked
// - extended set, bank 0, addr<=5Fh: indexed
// - opcode 001111 zero result discards next, one nop cycle
// - two-word next instruction adds second nop
// - quarters: decode, read, compute, write
module ifi_core
   import ifi_pkg::*;
(
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic [OPW-1:0]      instr,
   input  wire logic                next_two_word,
   input  wire logic                ext_en,
   input  wire logic [3:0]          bank_select_register,
   input  wire logic [11:0]         index_base,
   input  wire logic [7:0]          mem_rdata,
   output logic      [11:0]         mem_addr,
   output logic                     mem_rd,
   output logic                     mem_wr,
   output logic      [7:0]          mem_wdata,
   output logic      [7:0]          acc,
   output logic      [4:0]          flags,
   output logic      [1:0]          qphase,
   output logic                     skipping,
   output logic                     instr_done
);
   // =========================================================
   // quarter sequencer
   ifi_q_t      q;
   ifi_q_t      next_q;
   logic [1:0]  skip_left;
   logic        is_inc;
   logic        is_incsz;
   logic        dst_mem;
   logic [7:0]  operand;
   logic [8:0]  sum;
   logic [11:0] eff_addr;

   function automatic logic [8:0] inc9(input logic [7:0] v);
      inc9 = {1'b0, v} + {1'b0, ONE8};
   endfunction

   always_comb begin
      unique case (q)
         IFI_Q1: next_q = IFI_Q2;
         IFI_Q2: next_q = IFI_Q3;
         IFI_Q3: next_q = IFI_Q4;
         IFI_Q4: next_q = IFI_Q1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q <= IFI_Q1;
      end else begin
         q <= next_q;
      end
   end

   always_ff @(posedge mclk) begin
      qphase <= q;
   end

   // =========================================================
   // decode in Q1, held for the cycle
   ifi_addr u_addr (
      .f_addr               (instr[7:0]),
      .bank_sel             (instr[BANK_BIT]),
      .ext_en               (ext_en),
      .bank_select_register (bank_select_register),
      .index_base           (index_base),
      .eff_addr             (eff_addr)
   );

   wire active = (skip_left == 2'h0);

   always_ff @(posedge mclk) begin
      if (rst) begin
         is_inc   <= 1'b0;
         is_incsz <= 1'b0;
         dst_mem  <= 1'b0;
         mem_addr <= ZERO12;
      end else if (q == IFI_Q1) begin
         is_inc   <= active && instr[OP_MSB:OP_LSB] == OPC_INC;
         is_incsz <= active && instr[OP_MSB:OP_LSB] == OPC_INCSZ;
         dst_mem  <= instr[DST_BIT];
         mem_addr <= eff_addr;
      end
   end

   wire exec = is_inc || is_incsz;

   // =========================================================
   // read in Q2, compute in Q3, write in Q4
   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_rd  <= 1'b0;
         operand <= ZERO8;
         sum     <= 9'h000;
      end else begin
         // decode lands at the Q1 edge, so exec is only fresh from Q2
         mem_rd <= exec && q == IFI_Q2;
         if (q == IFI_Q2 && exec) begin
            operand <= mem_rdata;
         end
         if (q == IFI_Q3 && exec) begin
            sum <= inc9(operand);
         end
      end
   end

   wire wr_q = (q == IFI_Q4) && exec;

   always_ff @(posedge mclk) begin
      if (rst) begin
         mem_wr    <= 1'b0;
         mem_wdata <= ZERO8;
         acc       <= ACC_RST;
      end else begin
         mem_wr <= wr_q && dst_mem;
         if (wr_q && dst_mem) begin
            mem_wdata <= sum[7:0];
         end
         if (wr_q && !dst_mem) begin
            acc <= sum[7:0];
         end
      end
   end

   // operand low nibble all ones means a nibble carry out
   always_ff @(posedge mclk) begin
      if (rst) begin
         flags <= FLAGS_RST;
      end else if (wr_q && is_inc) begin
         flags[FL_C]  <= sum[8];
         flags[FL_DC] <= (operand[3:0] + ONE4) == 4'h0;
         flags[FL_Z]  <= sum[7:0] == ZERO8;
         flags[FL_N]  <= sum[7];
         // signed overflow only when the result crosses into the sign bit
         flags[FL_OV] <= sum[7:0] == SIGN_MASK;
      end
   end

   // =========================================================
   // skip control: nop cycles replace the fetched instruction
   always_ff @(posedge mclk) begin
      if (rst) begin
         skip_left <= 2'h0;
      end else if (wr_q && is_incsz && sum[7:0] == ZERO8) begin
         skip_left <= next_two_word ? 2'h2 : 2'h1;
      end else if (q == IFI_Q4 && !active) begin
         skip_left <= skip_left - 2'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         skipping   <= 1'b0;
         instr_done <= 1'b0;
      end else begin
         skipping   <= !active;
         instr_done <= q == IFI_Q4 && active;
      end
   end

   // =========================================================
   // checks
   chk_rd_in_q2: assert property (@(posedge mclk) disable iff (rst)
      mem_rd |-> $past(q) == IFI_Q2 && $past(exec))
      else $error("operand read outside second quarter");
   chk_wr_in_q4: assert property (@(posedge mclk) disable iff (rst)
      mem_wr |-> $past(q) == IFI_Q4 && $past(dst_mem))
      else $error("memory write outside fourth quarter");
   chk_incsz_flags: assert property (@(posedge mclk) disable iff (rst)
      $past(is_incsz) && !$past(is_inc) |-> $stable(flags))
      else $error("skip increment changed flags");
   chk_wrap_zero: assert property (@(posedge mclk) disable iff (rst)
      wr_q && is_inc && operand == 8'hff |=>
      flags[FL_Z] && flags[FL_C])
      else $error("wrap did not set zero and carry");
   chk_sum_plus1: assert property (@(posedge mclk) disable iff (rst)
      q == IFI_Q3 && exec |=> sum == {1'b0, operand} + 9'h001)
      else $error("result is not operand plus one");
   chk_skip_one: assert property (@(posedge mclk) disable iff (rst)
      wr_q && is_incsz && sum[7:0] == ZERO8 && !next_two_word
      |=> skip_left == 2'd1)
      else $error("single skip not armed");
   chk_skip_two: assert property (@(posedge mclk) disable iff (rst)
      wr_q && is_incsz && sum[7:0] == ZERO8 && next_two_word
      |=> skip_left == 2'd2)
      else $error("double skip not armed");
   chk_nop_quiet: assert property (@(posedge mclk) disable iff (rst)
      !active && q != IFI_Q1 |-> !exec)
      else $error("skipped cycle executed");
   chk_acc_write: assert property (@(posedge mclk) disable iff (rst)
      wr_q && !dst_mem |=> acc == $past(sum[7:0]))
      else $error("accumulator not written");
   chk_bank_addr: assert property (@(posedge mclk) disable iff (rst)
      q == IFI_Q1 && instr[BANK_BIT] |=>
      mem_addr[11:8] == $past(bank_select_register))
      else $error("banked address wrong");

   cov_inc: cover property (@(posedge mclk) wr_q && is_inc);
   cov_skip1: cover property (@(posedge mclk)
      skip_left == 2'd1 ##4 skip_left == 2'd0);
   cov_skip2: cover property (@(posedge mclk) skip_left == 2'd2);
   cov_idx: cover property (@(posedge mclk)
      q == IFI_Q1 && ext_en && !instr[BANK_BIT]
      && instr[7:0] <= IDX_LIMIT);
endmodule

/* inc/ifi_pkg.sv */
package ifi_pkg;
   // opcode layout of the byte-oriented increment instructions
   localparam int          OPW          = 16;
   localparam int          OP_MSB       = 15;
   localparam int          OP_LSB       = 10;
   localparam int          DST_BIT      = 9;
   localparam int          BANK_BIT     = 8;
   localparam logic [5:0]  OPC_INC      = 6'h0a;
   localparam logic [5:0]  OPC_INCSZ    = 6'h0f;
   localparam logic [7:0]  IDX_LIMIT    = 8'h5f;
   localparam logic [3:0]  ACCESS_HI    = 4'h0;
   localparam logic [3:0]  ACCESS_SFR   = 4'hf;
   localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
   localparam logic [7:0]  ONE8         = 8'h01;
   localparam logic [3:0]  ONE4         = 4'h1;
   localparam logic [11:0] ZERO12       = 12'h000;
   localparam logic [7:0]  ZERO8        = 8'h00;
   localparam logic [7:0]  SIGN_MASK    = 8'h80;
   // flag positions in the flag vector driven out by the core
   localparam int          FL_C         = 0;
   localparam int          FL_DC        = 1;
   localparam int          FL_Z         = 2;
   localparam int          FL_OV        = 3;
   localparam int          FL_N         = 4;
   localparam logic [4:0]  FLAGS_RST    = 5'h00;
   localparam logic [7:0]  ACC_RST      = 8'h00;

   // four quarter phases, gray along the cycle
   typedef enum logic [1:0] {
      IFI_Q1 = 2'b00,
      IFI_Q2 = 2'b01,
      IFI_Q3 = 2'b11,
      IFI_Q4 = 2'b10
   } ifi_q_t;
endpackage

/* logic/ifi_addr.sv */
`timescale 1ns/1ps
module ifi_addr
   import ifi_pkg::*;
(
   input  wire logic [7:0]  f_addr,
   input  wire logic        bank_sel,
   input  wire logic        ext_en,
   input  wire logic [3:0]  bank_select_register,
   input  wire logic [11:0] index_base,
   output logic      [11:0] eff_addr
);
   always_comb begin
      if (bank_sel) begin
         eff_addr = {bank_select_register, f_addr};
      end else if (ext_en && f_addr <= IDX_LIMIT) begin
         eff_addr = index_base + {4'h0, f_addr};
      end else if (f_addr < ACCESS_SPLIT) begin
         eff_addr = {ACCESS_HI, f_addr};
      end else begin
         eff_addr = {ACCESS_SFR, f_addr};
      end
   end
endmodule

/* dv/ifi_core_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
   tests_run++; \
   if ((got) !== (ex)) begin \
      errors++; \
      $display("ERROR %s exp %h got %h", nm, ex, got); \
   end \
end
module increment_file_instructions_tb
   import ifi_pkg::*;
;
   // ==========================================================
   // stimulus and observed signals
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] instr = 16'h0000;
   logic        next_two_word = 1'b0;
   logic        ext_en = 1'b0;
   logic [3:0]  bank_select_register = 4'h0;
   logic [11:0] index_base = 12'h000;
   logic [7:0]  mem_rdata = 8'h00;
   logic [11:0] mem_addr;
   logic        mem_rd, mem_wr, skipping, instr_done;
   logic [7:0]  mem_wdata, acc, r0, r1, r2, r3;
   logic [4:0]  flags;
   logic [1:0]  qphase;
   logic [7:0]  seed = 8'h19;
   logic [7:0]  exp_acc = ACC_RST;
   logic [4:0]  exp_flags = FLAGS_RST;
   int          errors = 0;
   int          tests_run = 0;

   always #10 mclk = ~mclk;

   ifi_core u_ifi_core (.mclk(mclk), .rst(rst), .instr(instr),
      .next_two_word(next_two_word), .ext_en(ext_en),
      .bank_select_register(bank_select_register),
      .index_base(index_base), .mem_rdata(mem_rdata),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .acc(acc), .flags(flags),
      .qphase(qphase), .skipping(skipping), .instr_done(instr_done));

   // ==========================================================
   // expectation helpers
   function automatic logic [7:0] rnd();
      seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
      return seed;
   endfunction

   function automatic logic [11:0] eff(input logic a, input logic [7:0] f,
         input logic x, input logic [3:0] b, input logic [11:0] ib);
      if (a) return {b, f};
      if (x && f <= IDX_LIMIT) return ib + {4'h0, f};
      return {(f < ACCESS_SPLIT) ? ACCESS_HI : ACCESS_SFR, f};
   endfunction

   function automatic logic [4:0] incflags(input logic [7:0] op);
      logic [7:0] r;
      r = op + ONE8;
      return {r[7], op == 8'h7f, r == ZERO8, op[3:0] == 4'hf, op == 8'hff};
   endfunction

   // qphase lags the quarter by one edge, gray along the cycle
   function automatic logic [1:0] gray2(input int n);
      return {n[1], n[1] ^ n[0]};
   endfunction

   // ==========================================================
   // one instruction slot plus the slots that follow it
   task automatic exec(input logic [15:0] ins, input logic [7:0] op,
         input logic tw, input logic x, input logic [3:0] b,
         input logic [11:0] ib);
      logic [7:0] res;
      logic [11:0] ea;
      logic       ok, inc, skip;
      int         nclk, rdn, wrn, dn;
      res = op + ONE8;
      ea = eff(ins[BANK_BIT], ins[7:0], x, b, ib);
      inc = ins[OP_MSB:OP_LSB] == OPC_INC;
      ok = inc || ins[OP_MSB:OP_LSB] == OPC_INCSZ;
      skip = ok && !inc && res == ZERO8;
      nclk = (skip && tw) ? 12 : 8;
      rdn = 0;
      wrn = 0;
      dn = 0;
      instr <= ins;
      mem_rdata <= op;
      next_two_word <= tw;
      ext_en <= x;
      bank_select_register <= b;
      index_base <= ib;
      for (int i = 1; i <= nclk; i++) begin
         @(posedge mclk);
         // a live follower shows up as an extra read if not discarded
         if (i == 4) instr <= skip ? {OPC_INC, 10'h070} : 16'h0000;
         #1;
         `CHK("qphase", gray2(i - 1), qphase)
         if (instr_done === 1'b1) dn++;
         if (mem_rd === 1'b1) begin
            rdn++;
            `CHK("rd_time", 2, i)
            `CHK("mem_addr", ea, mem_addr)
         end
         if (mem_wr === 1'b1) begin
            wrn++;
            `CHK("wr_time", 4, i)
            `CHK("mem_wdata", res, mem_wdata)
         end
         if (i >= 6 && i < nclk) `CHK("skipping", skip, skipping)
      end
      `CHK("reads", ok ? 1 : 0, rdn)
      `CHK("writes", (ok && ins[DST_BIT]) ? 1 : 0, wrn)
      // one pulse per executed cycle; discarded cycles give none
      if (ok) `CHK("done", skip ? 1 : 2, dn)
      if (ok && !ins[DST_BIT]) exp_acc = res;
      if (inc) exp_flags = incflags(op);
      `CHK("acc", exp_acc, acc)
      `CHK("flags", exp_flags, flags)
   endtask

   // ==========================================================
   // verdict
   task automatic conclude();
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      exec({OPC_INC, 2'b10, 8'hff}, 8'hff, 1'b0, 1'b0, 4'h3, 12'h100);
      exec({OPC_INC, 2'b00, 8'h7f}, 8'h7f, 1'b0, 1'b1, 4'h3, 12'h200);
      exec({OPC_INC, 2'b01, 8'h0f}, 8'h0f, 1'b0, 1'b1, 4'h5, 12'h200);
      exec({OPC_INCSZ, 2'b00, 8'h5f}, 8'hff, 1'b0, 1'b1, 4'h5, 12'h300);
      exec({OPC_INCSZ, 2'b10, 8'h60}, 8'hff, 1'b1, 1'b1, 4'h5, 12'h300);
      exec({OPC_INCSZ, 2'b11, 8'h10}, 8'h41, 1'b1, 1'b0, 4'ha, 12'h000);
      exec({6'h0b, 2'b10, 8'h22}, 8'h00, 1'b0, 1'b0, 4'h0, 12'h000);
      for (int n = 0; n < 60; n++) begin
         r0 = rnd();
         r1 = rnd();
         r2 = rnd();
         r3 = rnd();
         exec({(r2[1:0] == 2'b11) ? 6'h0b : (r2[1] ? OPC_INCSZ : OPC_INC),
               r2[2], r2[3], r1}, (r0[2:0] == 3'h0) ? 8'hff : r0, r2[5],
               r2[4], r2[7:4], {r3[3:0], r3});
      end
      conclude();
   end
endmodule
